// *** dv/edge_source_model.sv ***
// Far-side model: toggles the timer input pin n_i times, gap_i clocks apart.
// Assumes the bench pulses go_i for one cycle while busy_o is low.
`default_nettype none
module edge_source_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] n_i,
    input  wire logic [3:0] gap_i,
    output logic            pin_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin_o  = 1'b0;
        busy_o = 1'b0;
    end
    always begin
        @(posedge clk_i);
        if (go_i === 1'b1) begin
            busy_o <= 1'b1;
            repeat (n_i) begin
                repeat (gap_i) @(posedge clk_i);
                pin_o <= ~pin_o;
            end
            @(posedge clk_i);
            busy_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** dv/tb_timer_event_count_divider.sv ***
// Bench for the timer channel: registers, event count, divider, stop, disable.
// Assumes package, design, edge source model and checker are compiled first.
`default_nettype none
module tb_timer_event_count_divider;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_event_count_divider_pkg::*;
    logic        clk_i = 1'b0, nrst_i = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0;
    logic        wt, pin, tout, irq, busy, tprev;
    logic [7:0]  addr = 8'h00, n = 8'h00;
    logic [3:0]  gap = 4'h4;
    logic [31:0] wd = 32'h0, rq, rdata;
    int          mismatches = 0, num_checks = 0, irqs = 0, outs = 0;
    always #5 clk_i = ~clk_i;
    timer_event_count_divider uut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rq), .avs_waitrequest_o(wt), .timer_input_pin_i(pin),
        .timer_output_o(tout), .channel_interrupt_o(irq));
    edge_source_model src (.clk_i(clk_i), .go_i(go), .n_i(n), .gap_i(gap), .pin_o(pin),
        .busy_o(busy));
    always @(negedge clk_i) begin
        if (irq === 1'b1) irqs++;
        if (tout !== tprev) outs++;
        tprev = tout;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk_i);
            k++;
        end while (wt !== 1'b0 && k < 20);
        if (k >= 20) begin
            mismatches++;
            summarize();
        end
        rdata = rq;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    task automatic edges(input logic [7:0] cnt);
        int k;
        k = 0;
        n <= cnt;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        do begin
            @(posedge clk_i);
            k++;
        end while (busy !== 1'b0 && k < 3000);
        if (k >= 3000) begin
            mismatches++;
            summarize();
        end
        repeat (6) @(posedge clk_i);
    endtask
    task automatic start(input logic [2:0] om, input logic [1:0] es, input logic sb,
                         input logic [15:0] d);
        bus(1'b1, OFS_TRIGGER, 32'h2);
        bus(1'b1, OFS_MODE, (32'h1 << MODE_CCS) | (32'(es) << MODE_EDGE_LO)
            | (32'(om) << MODE_OPMODE_LO) | 32'(sb));
        bus(1'b1, OFS_DATA, {16'h0, d});
        irqs = 0;
        outs = 0;
        bus(1'b1, OFS_TRIGGER, 32'h1);
    endtask
    initial begin
        int v;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        bus(1'b1, OFS_DATA, 32'h5);
        rc(OFS_DATA, 32'h0);
        rc(OFS_MODE, {16'h0, MODE_RESET});
        rc(8'h30, 32'h0);
        bus(1'b1, OFS_PER_EN, 32'h1);
        bus(1'b1, OFS_OUT_EN, 32'h0);
        for (int e = 0; e < 3; e++) begin
            start(OPMODE_EVENT, 2'(e), 1'b0, 16'h2);
            rc(OFS_COUNTER, 32'h2);
            rc(OFS_STATUS, 32'h1);
            rc(OFS_TRIGGER, 32'h0);
            v = (e == 2 || (e == 1) == !pin) ? 1 : 0;
            edges(8'd1);
            rc(OFS_COUNTER, 32'(2 - v));
            edges(8'd11);
            chk(32'(irqs), (e == 2) ? 32'd4 : 32'd2);
            rc(OFS_COUNTER, 32'h2);
        end
        start(OPMODE_EVENT, EDGE_BOTH, 1'b0, 16'h2);
        bus(1'b1, OFS_DATA, 32'h4);
        gap <= 4'h7;
        edges(8'd3);
        chk(32'(irqs), 32'd1);
        rc(OFS_COUNTER, 32'h4);
        edges(8'd2);
        bus(1'b1, OFS_TRIGGER, 32'h2);
        rc(OFS_STATUS, 32'h0);
        edges(8'd6);
        rc(OFS_COUNTER, 32'h2);
        chk(32'(irqs), 32'd1);
        gap <= 4'h4;
        start(OPMODE_EVENT, EDGE_BOTH, 1'b1, 16'h2);
        repeat (2) @(posedge clk_i);
        chk(32'(irqs), 32'd1);
        bus(1'b1, OFS_TRIGGER, 32'h2);
        bus(1'b1, OFS_NF_EN, 32'h1);
        bus(1'b1, OFS_OUT_EN, 32'h1);
        start(OPMODE_INTERVAL, EDGE_RISE, 1'b0, 16'h1);
        edges(8'd18);
        chk(32'(outs), 32'd4);
        chk(32'(irqs), 32'd4);
        bus(1'b1, OFS_OUT_VAL, 32'h1);
        bus(1'b1, OFS_PER_EN, 32'h0);
        rc(OFS_STATUS, 32'h0);
        rc(OFS_COUNTER, 32'h0);
        chk({31'h0, tout}, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire

// *** dv/timer_event_count_divider_props.sv ***
// Port checker for the timer channel.
// Assumes a bind into timer_event_count_divider and one clock domain.
`default_nettype none
module timer_event_count_divider_props
    import timer_event_count_divider_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              nrst_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0]        avs_byteenable_i,
    input wire logic [DATA_W-1:0] avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic              timer_input_pin_i,
    input wire logic              timer_output_o,
    input wire logic              channel_interrupt_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic      per_q, stop_q;
    wire logic acc = avs_write_i && !avs_waitrequest_o;
    wire logic rdy = avs_read_i && !avs_waitrequest_o;
    // Tracks peripheral enable and the stopped state from accepted writes
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            per_q  <= 1'b0;
            stop_q <= 1'b1;
        end else if (acc && avs_address_i == OFS_PER_EN) begin
            per_q  <= avs_writedata_i[0];
            stop_q <= stop_q || !avs_writedata_i[0];
        end else if (acc && per_q && avs_address_i == OFS_TRIGGER) begin
            stop_q <= avs_writedata_i[1] || (stop_q && !avs_writedata_i[0]);
        end
    end
    wait_first_a: assert property ($rose(avs_read_i || avs_write_i)
        |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bus wait timing wrong");
    wait_idle_a: assert property (!avs_read_i && !avs_write_i
        |-> !avs_waitrequest_o) else $error("wait without request");
    irq_pulse_a: assert property (channel_interrupt_o
        |=> !channel_interrupt_o) else $error("interrupt longer than one cycle");
    trig_zero_a: assert property (rdy && avs_address_i == OFS_TRIGGER
        |-> avs_readdata_o == 32'h0) else $error("trigger reads nonzero");
    upper_zero_a: assert property (rdy
        |-> avs_readdata_o[31:16] == 16'h0) else $error("upper read bits set");
    rst_quiet_a: assert property ($rose(nrst_i)
        |-> (!channel_interrupt_o && !timer_output_o) [*2]) else $error("active after reset");
    off_quiet_a: assert property (!per_q && !$past(per_q, 2)
        |-> !channel_interrupt_o && !timer_output_o) else $error("active while disabled");
    stop_quiet_a: assert property (stop_q && $past(stop_q, 2)
        |-> !channel_interrupt_o) else $error("interrupt while stopped");
endmodule
bind timer_event_count_divider timer_event_count_divider_props chk_u (.*);
`default_nettype wire

// *** rtl/timer_event_count_divider.sv ***
// One timer channel: external event counter and clock frequency divider.
// Assumes an Avalon-MM master and a timer input pin synchronous to clk_i.
//
// What this block does
// RULE1: Event mode start trigger copies data register into the down-counter, then awaits edges.
// RULE2: Event mode decrements the counter once per valid input edge.
// RULE3: Counter at 0000H plus another edge reloads data and raises the interrupt.
// RULE4: Edges between event interrupts equal data value plus one.
// RULE5: Data register writes take effect only at the next reload.
// RULE6: Mode field 011B selects event count, 000B interval timing for dividing.
// RULE7: Edge select 00B falling, 01B rising, 10B both; 11B not allowed.
// RULE8: Count clock select 1 counts input pin edges, not the operation clock.
// RULE9: Start trigger select 000B means only software start triggers the channel.
// RULE10: Operation clock select 00B prescaler 0, 10B prescaler 1; others split only.
// RULE11: Split bit chooses 16-bit (0) or 8-bit (1) counting on capable channels.
// RULE12: Start behaviour bit 1 pulses interrupt and toggles output at count start.
// RULE13: Start and stop trigger bits clear themselves and read as zero.
// RULE14: Start sets enable status and counts; stop clears it and freezes counter.
// RULE15: Stop never clears the counter value.
// RULE16: Software keeps output enable at 0 in event mode to avoid irregular output.
// RULE17: Counter is readable at all times; software leaves mode and output setup alone.
// RULE18: Clearing peripheral enable resets the whole channel and blocks register writes.
// RULE19: Divider mode exists only on the divider-capable channel, input to output.
// RULE20: Divider mode loads the counter on the first valid edge after start.
// RULE21: Divider counter decrements per edge, toggles output and reloads at 0000H.
// RULE22: Single-edge divider output is input frequency over twice data plus one.
// RULE23: Input is synchronised to operation clock; filter needs two stable samples.
// RULE24: Interrupt is one clock-cycle pulse per reload event.
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`default_nettype none
module timer_event_count_divider
    import timer_event_count_divider_pkg::*;
#(
    parameter bit DIVIDER_CAPABLE = 1'b1,
    parameter bit SPLIT_CAPABLE   = 1'b0
) (
    input  wire logic                                       clk_i,
    input  wire logic                                       nrst_i,
    input  wire logic [timer_event_count_divider_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                                       avs_read_i,
    input  wire logic                                       avs_write_i,
    input  wire logic [timer_event_count_divider_pkg::DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]                                 avs_byteenable_i,
    output logic      [timer_event_count_divider_pkg::DATA_W-1:0] avs_readdata_o,
    output logic                                            avs_waitrequest_o,
    input  wire logic                                       timer_input_pin_i,
    output logic                                            timer_output_o,
    output logic                                            channel_interrupt_o
);
    import timer_event_count_divider_pkg::*;

    // Reset synchroniser
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // Registers
    logic [15:0]      channel_mode_reg;
    logic [15:0]      channel_data_reg;
    logic [CNT_W-1:0] channel_counter_reg;
    logic             channel_enable_status_reg;
    logic             output_value_reg;
    logic             output_enable_reg;
    logic             output_level_reg;
    logic             output_mode_reg;
    logic             peripheral_enable_reg;
    logic             noise_filter_enable_reg;
    logic [15:0]      prescaler_select_reg;
    logic             channel_interrupt_reg;
    chan_state_t      state_reg;

    // Bus slave: one wait cycle, answer from flip-flops
    logic             ack_reg;
    logic [DATA_W-1:0] readdata_reg;
    logic             req;
    logic             wr_take;
    logic [15:0]      wdata16;
    logic [15:0]      wmask16;
    logic [DATA_W-1:0] read_mux;

    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_reg;
    assign avs_readdata_o    = readdata_reg;
    assign wr_take           = avs_write_i & ack_reg;
    assign wdata16           = avs_writedata_i[15:0];
    assign wmask16           = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    always_comb begin
        read_mux = '0;
        unique case (avs_address_i)
            OFS_MODE:     read_mux[15:0] = channel_mode_reg;
            OFS_DATA:     read_mux[15:0] = channel_data_reg;
            OFS_COUNTER:  read_mux[15:0] = channel_counter_reg; // RULE17
            OFS_TRIGGER:  read_mux       = '0; // RULE13
            OFS_STATUS:   read_mux[0]    = channel_enable_status_reg;
            OFS_OUT_VAL:  read_mux[0]    = output_value_reg;
            OFS_OUT_EN:   read_mux[0]    = output_enable_reg;
            OFS_OUT_LVL:  read_mux[0]    = output_level_reg;
            OFS_OUT_MODE: read_mux[0]    = output_mode_reg;
            OFS_PER_EN:   read_mux[0]    = peripheral_enable_reg;
            OFS_NF_EN:    read_mux[0]    = noise_filter_enable_reg;
            OFS_PRESCALE: read_mux[15:0] = prescaler_select_reg;
            default:      read_mux       = '0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            readdata_reg <= '0;
        end else if (avs_read_i && !ack_reg) begin
            readdata_reg <= read_mux;
        end
    end

    // Unit enable and block-wide clear
    logic unit_clr;
    logic wr_ok;
    assign unit_clr = ~peripheral_enable_reg;
    assign wr_ok    = wr_take & peripheral_enable_reg; // RULE18

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            peripheral_enable_reg <= 1'b0;
        end else if (wr_take && avs_address_i == OFS_PER_EN && avs_byteenable_i[0]) begin
            peripheral_enable_reg <= avs_writedata_i[0];
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            channel_mode_reg        <= MODE_RESET;
            channel_data_reg        <= DATA_RESET;
            prescaler_select_reg    <= PRESCALE_RESET;
            output_enable_reg       <= 1'b0;
            output_level_reg        <= 1'b0;
            output_mode_reg         <= 1'b0;
            noise_filter_enable_reg <= 1'b0;
        end else if (unit_clr) begin // RULE18
            channel_mode_reg        <= MODE_RESET;
            channel_data_reg        <= DATA_RESET;
            prescaler_select_reg    <= PRESCALE_RESET;
            output_enable_reg       <= 1'b0;
            output_level_reg        <= 1'b0;
            output_mode_reg         <= 1'b0;
            noise_filter_enable_reg <= 1'b0;
        end else if (wr_ok) begin
            unique case (avs_address_i)
                OFS_MODE: begin
                    channel_mode_reg <= (channel_mode_reg & ~wmask16) | (wdata16 & wmask16);
                end
                OFS_DATA: begin
                    channel_data_reg <= (channel_data_reg & ~wmask16) | (wdata16 & wmask16);
                end
                OFS_PRESCALE: begin
                    prescaler_select_reg <= (prescaler_select_reg & ~wmask16)
                                          | (wdata16 & wmask16);
                end
                OFS_OUT_EN: begin
                    if (avs_byteenable_i[0]) output_enable_reg <= avs_writedata_i[0];
                end
                OFS_OUT_LVL: begin
                    if (avs_byteenable_i[0]) output_level_reg <= avs_writedata_i[0];
                end
                OFS_OUT_MODE: begin
                    if (avs_byteenable_i[0]) output_mode_reg <= avs_writedata_i[0];
                end
                OFS_NF_EN: begin
                    if (avs_byteenable_i[0]) noise_filter_enable_reg <= avs_writedata_i[0];
                end
                default: begin
                end
            endcase
        end
    end

    // Mode fields
    logic       start_behaviour_bit;
    logic [2:0] op_mode_field;
    logic [1:0] input_edge_select;
    logic [2:0] start_trigger_select;
    logic       byte_split_bit;
    logic       count_clock_select;
    logic [1:0] op_clock_select;
    logic       split_on;
    assign start_behaviour_bit  = channel_mode_reg[MODE_START_BEH];
    assign op_mode_field        = channel_mode_reg[MODE_OPMODE_LO +: 3];
    assign input_edge_select    = channel_mode_reg[MODE_EDGE_LO +: 2];
    assign start_trigger_select = channel_mode_reg[MODE_STS_LO +: 3];
    assign byte_split_bit       = channel_mode_reg[MODE_SPLIT];
    assign count_clock_select   = channel_mode_reg[MODE_CCS];
    assign op_clock_select      = channel_mode_reg[MODE_CKS_LO +: 2];
    assign split_on             = SPLIT_CAPABLE & byte_split_bit; // RULE11

    // Prescaler: clock k ticks every 2**field_k cycles
    logic [15:0] pre_cnt_reg;
    logic [3:0]  ck_tick;
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pre_cnt_reg <= '0;
        end else if (unit_clr) begin
            pre_cnt_reg <= '0;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 16'h0001;
        end
    end

    genvar gk;
    generate
        for (gk = 0; gk < 4; gk++) begin : g_ck
            logic [15:0] mask;
            assign mask        = (16'h0001 << prescaler_select_reg[4*gk +: 4]) - 16'h0001;
            assign ck_tick[gk] = (pre_cnt_reg & mask) == mask;
        end
    endgenerate

    // Operation clock tick from the selected prescaler
    logic op_tick;
    always_comb begin
        unique case (op_clock_select)
            2'h0: op_tick = ck_tick[0]; // RULE10
            2'h2: op_tick = ck_tick[1]; // RULE10
            2'h1: op_tick = split_on ? ck_tick[2] : ck_tick[0];
            2'h3: op_tick = split_on ? ck_tick[3] : ck_tick[1];
        endcase
    end

    // Input synchronisation and noise filter on the operation clock
    logic samp1_reg;
    logic samp2_reg;
    logic filt_reg;
    logic filt_prev_reg;
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            samp1_reg     <= 1'b0;
            samp2_reg     <= 1'b0;
            filt_reg      <= 1'b0;
            filt_prev_reg <= 1'b0;
        end else if (unit_clr) begin
            samp1_reg     <= 1'b0;
            samp2_reg     <= 1'b0;
            filt_reg      <= 1'b0;
            filt_prev_reg <= 1'b0;
        end else begin
            filt_prev_reg <= filt_reg;
            if (op_tick) begin
                samp1_reg <= timer_input_pin_i; // RULE23
                samp2_reg <= samp1_reg;
                if (!noise_filter_enable_reg) begin
                    filt_reg <= samp1_reg; // RULE23
                end else if (samp1_reg == samp2_reg) begin
                    filt_reg <= samp2_reg; // RULE23
                end
            end
        end
    end

    // Valid edge detection
    logic rise;
    logic fall;
    logic valid_edge;
    assign rise = filt_reg & ~filt_prev_reg;
    assign fall = ~filt_reg & filt_prev_reg;
    always_comb begin
        unique case (input_edge_select)
            EDGE_FALL: valid_edge = fall; // RULE7
            EDGE_RISE: valid_edge = rise; // RULE7
            EDGE_BOTH: valid_edge = rise | fall; // RULE7
            default:   valid_edge = 1'b0;
        endcase
    end

    // Count source and mode decode
    logic count_tick;
    logic mode_event;
    logic mode_divide;
    logic mode_ok;
    assign count_tick  = count_clock_select ? valid_edge : op_tick; // RULE8 RULE2
    assign mode_event  = op_mode_field == OPMODE_EVENT; // RULE6
    assign mode_divide = (op_mode_field == OPMODE_INTERVAL)
                       & (DIVIDER_CAPABLE | ~count_clock_select); // RULE6 RULE19
    assign mode_ok     = mode_event | mode_divide;

    // Triggers: write-only pulses, never stored
    logic start_trig;
    logic stop_trig;
    assign start_trig = wr_ok & (avs_address_i == OFS_TRIGGER) & avs_byteenable_i[0]
                      & avs_writedata_i[TRIG_START]
                      & (start_trigger_select == STS_SOFTWARE) & mode_ok; // RULE9 RULE13
    assign stop_trig  = wr_ok & (avs_address_i == OFS_TRIGGER) & avs_byteenable_i[0]
                      & avs_writedata_i[TRIG_STOP]; // RULE13

    // Counter reload and zero detect honour the split width
    logic [CNT_W-1:0] reload_val;
    logic             cnt_zero;
    logic [CNT_W-1:0] cnt_dec;
    assign reload_val = split_on ? {channel_counter_reg[15:8], channel_data_reg[7:0]}
                                 : channel_data_reg;
    assign cnt_zero   = split_on ? (channel_counter_reg[7:0] == 8'h00)
                                 : (channel_counter_reg == 16'h0000);
    assign cnt_dec    = split_on ? {channel_counter_reg[15:8], channel_counter_reg[7:0] - 8'h01}
                                 : channel_counter_reg - 16'h0001;

    // Channel sequencer
    logic fire;
    logic start_fire;
    always_comb begin
        fire       = 1'b0;
        start_fire = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                start_fire = start_trig & mode_event & start_behaviour_bit; // RULE12
            end
            ST_FIRST: begin
                start_fire = count_tick & start_behaviour_bit; // RULE12
            end
            ST_RUN: begin
                fire = count_tick & cnt_zero; // RULE3 RULE21
            end
            default: begin
            end
        endcase
        if (stop_trig) begin
            fire       = 1'b0;
            start_fire = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg                 <= ST_IDLE;
            channel_counter_reg       <= '0;
            channel_enable_status_reg <= 1'b0;
        end else if (unit_clr) begin // RULE18
            state_reg                 <= ST_IDLE;
            channel_counter_reg       <= '0;
            channel_enable_status_reg <= 1'b0;
        end else if (stop_trig) begin
            state_reg                 <= ST_IDLE; // RULE14 RULE15
            channel_enable_status_reg <= 1'b0; // RULE14
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start_trig) begin
                        channel_enable_status_reg <= 1'b1; // RULE14
                        if (mode_event) begin
                            channel_counter_reg <= channel_data_reg; // RULE1
                            state_reg           <= ST_RUN;
                        end else begin
                            state_reg <= ST_FIRST; // RULE20
                        end
                    end
                end
                ST_FIRST: begin
                    if (count_tick) begin
                        channel_counter_reg <= channel_data_reg; // RULE20
                        state_reg           <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (count_tick) begin
                        if (cnt_zero) begin
                            channel_counter_reg <= reload_val; // RULE3 RULE4 RULE5 RULE21
                        end else begin
                            channel_counter_reg <= cnt_dec; // RULE2 RULE21
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Interrupt pulse, one clock per reload or qualifying start
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            channel_interrupt_reg <= 1'b0;
        end else begin
            channel_interrupt_reg <= ~unit_clr & (fire | start_fire); // RULE24 RULE3
        end
    end
    assign channel_interrupt_o = channel_interrupt_reg;

    // Output value: software writes it; hardware toggles when output is enabled
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            output_value_reg <= 1'b0;
        end else if (unit_clr) begin
            output_value_reg <= 1'b0;
        end else if (wr_ok && avs_address_i == OFS_OUT_VAL && avs_byteenable_i[0]) begin
            output_value_reg <= avs_writedata_i[0];
        end else if (output_enable_reg && (fire || start_fire)) begin
            output_value_reg <= ~output_value_reg; // RULE21 RULE22 RULE12 RULE16
        end
    end

    // Output pin with level inversion
    logic timer_output_reg;
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            timer_output_reg <= 1'b0;
        end else begin
            timer_output_reg <= output_value_reg ^ output_level_reg; // RULE19
        end
    end
    assign timer_output_o = timer_output_reg;

endmodule
`default_nettype wire

// *** rtl/timer_event_count_divider_pkg.sv ***
// Constants for one timer channel: register map, field layout, reset values.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`default_nettype none
package timer_event_count_divider_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_DATA     = 8'h04;
    localparam logic [7:0] OFS_COUNTER  = 8'h08;
    localparam logic [7:0] OFS_TRIGGER  = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_OUT_VAL  = 8'h14;
    localparam logic [7:0] OFS_OUT_EN   = 8'h18;
    localparam logic [7:0] OFS_OUT_LVL  = 8'h1C;
    localparam logic [7:0] OFS_OUT_MODE = 8'h20;
    localparam logic [7:0] OFS_PER_EN   = 8'h24;
    localparam logic [7:0] OFS_NF_EN    = 8'h28;
    localparam logic [7:0] OFS_PRESCALE = 8'h2C;

    // Mode register field positions
    localparam int MODE_START_BEH = 0;
    localparam int MODE_OPMODE_LO = 1;
    localparam int MODE_EDGE_LO   = 6;
    localparam int MODE_STS_LO    = 8;
    localparam int MODE_SPLIT     = 11;
    localparam int MODE_CCS       = 12;
    localparam int MODE_CKS_LO    = 14;

    // Trigger register bits
    localparam int TRIG_START = 0;
    localparam int TRIG_STOP  = 1;

    // Field encodings
    localparam logic [2:0] OPMODE_INTERVAL = 3'h0;
    localparam logic [2:0] OPMODE_EVENT    = 3'h3;
    localparam logic [1:0] EDGE_FALL       = 2'h0;
    localparam logic [1:0] EDGE_RISE       = 2'h1;
    localparam logic [1:0] EDGE_BOTH       = 2'h2;
    localparam logic [2:0] STS_SOFTWARE    = 3'h0;

    // Reset values
    localparam logic [15:0] MODE_RESET     = 16'h0000;
    localparam logic [15:0] DATA_RESET     = 16'h0000;
    localparam logic [15:0] PRESCALE_RESET = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FIRST = 3'b010,
        ST_RUN   = 3'b100
    } chan_state_t;

endpackage
`default_nettype wire
